// [core/synth_ctl.sv]
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps

// Summary of operation
// - Reference divisor R is a 10-bit field accepting 1 through 1023.
// - Feedback divisor N is a 12-bit field accepting 1 through 4095.
// - Sampling clock is oscillator divided by the 4-bit output divisor field.
// - Locked oscillator runs at reference times N over R.
// - 4-bit pump code sets bias current, 25 uA steps, 25 to 400 uA.
// - Trigger bit 0-to-1 write starts calibration; status bit shows calibration done.
// - Leaving soft reset starts a calibration automatically.
// - Two read-only drift flags, low and high side, sit in status.
// - Synth and reference-divider enables share one register; output and bias another.
// - Synthesized clock reaches converter only while gate enable bit is 1.
// - 3-bit field delays data output clock in oscillator cycles, up to seven.
// - 5-bit resistor and three capacitor codes, each in own register.
// - R split over two byte registers, N over next two, output divisor shares.
// - Clock-source bit 1 takes sampling clock from the synthesizer.
module synth_ctl (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // Analog synthesizer status, asynchronous
   input  wire logic        cal_done_i,
   input  wire logic        drift_low_i,
   input  wire logic        drift_high_i,
   // Divider and loop settings
   output logic      [9:0]  ref_divisor_o,
   output logic      [11:0] feedback_divisor_o,
   output logic      [3:0]  output_divisor_o,
   output logic      [3:0]  pump_current_code_o,
   output logic      [4:0]  filter_resistor_code_o,
   output logic      [4:0]  filter_cap_one_code_o,
   output logic      [4:0]  filter_cap_two_code_o,
   output logic      [4:0]  filter_cap_three_code_o,
   // Enables and clock steering
   output logic             synth_enable_o,
   output logic             ref_divisor_enable_o,
   output logic             synth_output_enable_o,
   output logic             synth_bias_enable_o,
   output logic             sample_clk_gate_o,
   output logic      [2:0]  data_clock_delay_cycles_o,
   output logic             sample_clk_from_synth_o,
   // Soft reset and calibration
   output logic             soft_reset_o,
   output logic             cal_start_o,
   output logic             cal_busy_o
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0]                 soft_rst;
      logic [7:0]                 clk_src;
      logic [7:0]                 ref_low;
      logic [7:0]                 ref_high;
      logic [7:0]                 fb_low;
      logic [7:0]                 fb_high;
      logic [7:0]                 pump;
      logic [7:0]                 master_en;
      logic [7:0]                 filt_res;
      logic [7:0]                 filt_cap3;
      logic [7:0]                 filt_cap1;
      logic [7:0]                 filt_cap2;
      logic [7:0]                 out_bias_en;
      logic [7:0]                 cal_trig;
      logic [7:0]                 clk_gate;
      logic [7:0]                 rdata;
      logic [2:0]                 done_sync;
      logic [1:0]                 drl_sync;
      logic [1:0]                 drh_sync;
      logic                       cal_ok;
      synth_ctl_pkg::cal_state_e  cal_state;
   } state_s;

   state_s st_ff;
   state_s nxt_st;

   logic       trig_rise;
   logic       srst_exit;
   logic       done_rise;
   logic [7:0] status_byte;

   // ************************************************************
   // Event detection
   // ************************************************************
   // Edges are taken from the written data against the held bit, so a
   // write of the same value twice never restarts calibration
   always_comb begin
      trig_rise = reg_wr_i && (reg_addr_i == synth_ctl_pkg::OFS_CAL_TRIG)
                  && reg_wdata_i[synth_ctl_pkg::BIT_CAL_TRIG]
                  && !st_ff.cal_trig[synth_ctl_pkg::BIT_CAL_TRIG];
      srst_exit = reg_wr_i && (reg_addr_i == synth_ctl_pkg::OFS_SOFT_RESET)
                  && !reg_wdata_i[synth_ctl_pkg::BIT_SOFT_RESET]
                  && st_ff.soft_rst[synth_ctl_pkg::BIT_SOFT_RESET];
      // Second and third stages only; first stage feeds the second alone
      done_rise = st_ff.done_sync[1] && !st_ff.done_sync[2];
   end

   // Status byte: done flag plus synchronised drift levels
   always_comb begin
      status_byte = 8'h00;
      status_byte[synth_ctl_pkg::BIT_STAT_CAL_OK]  = st_ff.cal_ok
                  && (st_ff.cal_state == synth_ctl_pkg::CAL_IDLE);
      status_byte[synth_ctl_pkg::BIT_STAT_DRIFT_L] = st_ff.drl_sync[1];
      status_byte[synth_ctl_pkg::BIT_STAT_DRIFT_H] = st_ff.drh_sync[1];
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      nxt_st = st_ff;
      // Two-flop synchronisers, done has a third stage for the edge
      nxt_st.done_sync = {st_ff.done_sync[1:0], cal_done_i};
      nxt_st.drl_sync  = {st_ff.drl_sync[0], drift_low_i};
      nxt_st.drh_sync  = {st_ff.drh_sync[0], drift_high_i};

      // Register writes; unmapped and read-only offsets are ignored
      if (reg_wr_i) begin
         case (reg_addr_i)
            synth_ctl_pkg::OFS_SOFT_RESET:  nxt_st.soft_rst    = reg_wdata_i;
            synth_ctl_pkg::OFS_CLK_SOURCE:  nxt_st.clk_src     = reg_wdata_i;
            synth_ctl_pkg::OFS_REF_LOW:     nxt_st.ref_low     = reg_wdata_i;
            synth_ctl_pkg::OFS_REF_HIGH:    nxt_st.ref_high    = reg_wdata_i;
            synth_ctl_pkg::OFS_FB_LOW:      nxt_st.fb_low      = reg_wdata_i;
            synth_ctl_pkg::OFS_FB_HIGH:     nxt_st.fb_high     = reg_wdata_i;
            synth_ctl_pkg::OFS_PUMP:        nxt_st.pump        = reg_wdata_i;
            synth_ctl_pkg::OFS_MASTER_EN:   nxt_st.master_en   = reg_wdata_i;
            synth_ctl_pkg::OFS_FILT_RES:    nxt_st.filt_res    = reg_wdata_i;
            synth_ctl_pkg::OFS_FILT_CAP3:   nxt_st.filt_cap3   = reg_wdata_i;
            synth_ctl_pkg::OFS_FILT_CAP1:   nxt_st.filt_cap1   = reg_wdata_i;
            synth_ctl_pkg::OFS_FILT_CAP2:   nxt_st.filt_cap2   = reg_wdata_i;
            synth_ctl_pkg::OFS_OUT_BIAS_EN: nxt_st.out_bias_en = reg_wdata_i;
            synth_ctl_pkg::OFS_CAL_TRIG:    nxt_st.cal_trig    = reg_wdata_i;
            synth_ctl_pkg::OFS_CLK_GATE:    nxt_st.clk_gate    = reg_wdata_i;
            default: ;
         endcase
      end

      // Read data stands one cycle after the strobe, zero when idle
      nxt_st.rdata = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            synth_ctl_pkg::OFS_SOFT_RESET:  nxt_st.rdata = st_ff.soft_rst;
            synth_ctl_pkg::OFS_CLK_SOURCE:  nxt_st.rdata = st_ff.clk_src;
            synth_ctl_pkg::OFS_REF_LOW:     nxt_st.rdata = st_ff.ref_low;
            synth_ctl_pkg::OFS_REF_HIGH:    nxt_st.rdata = st_ff.ref_high;
            synth_ctl_pkg::OFS_FB_LOW:      nxt_st.rdata = st_ff.fb_low;
            synth_ctl_pkg::OFS_FB_HIGH:     nxt_st.rdata = st_ff.fb_high;
            synth_ctl_pkg::OFS_PUMP:        nxt_st.rdata = st_ff.pump;
            synth_ctl_pkg::OFS_MASTER_EN:   nxt_st.rdata = st_ff.master_en;
            synth_ctl_pkg::OFS_FILT_RES:    nxt_st.rdata = st_ff.filt_res;
            synth_ctl_pkg::OFS_FILT_CAP3:   nxt_st.rdata = st_ff.filt_cap3;
            synth_ctl_pkg::OFS_FILT_CAP1:   nxt_st.rdata = st_ff.filt_cap1;
            synth_ctl_pkg::OFS_FILT_CAP2:   nxt_st.rdata = st_ff.filt_cap2;
            synth_ctl_pkg::OFS_OUT_BIAS_EN: nxt_st.rdata = st_ff.out_bias_en;
            synth_ctl_pkg::OFS_CAL_TRIG:    nxt_st.rdata = st_ff.cal_trig;
            synth_ctl_pkg::OFS_CLK_GATE:    nxt_st.rdata = st_ff.clk_gate;
            synth_ctl_pkg::OFS_STATUS:      nxt_st.rdata = status_byte;
            default:                        nxt_st.rdata = 8'h00;
         endcase
      end

      // Calibration sequencer; a new request while busy is dropped since
      // the analog loop cannot restart mid-sequence
      case (st_ff.cal_state)
         synth_ctl_pkg::CAL_IDLE: begin
            if (trig_rise || srst_exit) begin
               nxt_st.cal_state = synth_ctl_pkg::CAL_START;
               nxt_st.cal_ok    = 1'b0;
            end
         end
         synth_ctl_pkg::CAL_START: begin
            nxt_st.cal_state = synth_ctl_pkg::CAL_WAIT;
         end
         synth_ctl_pkg::CAL_WAIT: begin
            if (done_rise) begin
               nxt_st.cal_state = synth_ctl_pkg::CAL_IDLE;
               nxt_st.cal_ok    = 1'b1;
            end
         end
         default: begin
            nxt_st.cal_state = synth_ctl_pkg::CAL_IDLE;
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff             <= '0;
         st_ff.ref_low     <= synth_ctl_pkg::RST_REF_LOW;
         st_ff.fb_low      <= synth_ctl_pkg::RST_FB_LOW;
         st_ff.pump        <= synth_ctl_pkg::RST_PUMP;
         st_ff.soft_rst    <= synth_ctl_pkg::RST_REG;
         st_ff.cal_state   <= synth_ctl_pkg::CAL_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Divider fields; the analog dividers treat the code as the integer divisor
   assign ref_divisor_o       = {st_ff.ref_high[1:0], st_ff.ref_low};
   assign feedback_divisor_o  = {st_ff.fb_high[3:0], st_ff.fb_low};
   assign output_divisor_o    = st_ff.ref_high[synth_ctl_pkg::LSB_OUT_DIV +: 4];
   assign pump_current_code_o = st_ff.pump[3:0];

   // Loop filter codes
   assign filter_resistor_code_o   = st_ff.filt_res[4:0];
   assign filter_cap_one_code_o    = st_ff.filt_cap1[4:0];
   assign filter_cap_two_code_o    = st_ff.filt_cap2[4:0];
   assign filter_cap_three_code_o  = st_ff.filt_cap3[4:0];

   // Enables and clock steering
   assign synth_enable_o            = st_ff.master_en[synth_ctl_pkg::BIT_SYNTH_EN];
   assign ref_divisor_enable_o      = st_ff.master_en[synth_ctl_pkg::BIT_REFDIV_EN];
   assign synth_output_enable_o     = st_ff.out_bias_en[synth_ctl_pkg::BIT_OUT_EN];
   assign synth_bias_enable_o       = st_ff.out_bias_en[synth_ctl_pkg::BIT_BIAS_EN];
   assign sample_clk_gate_o         = st_ff.clk_gate[synth_ctl_pkg::BIT_CLK_GATE];
   assign data_clock_delay_cycles_o = st_ff.clk_gate[synth_ctl_pkg::LSB_DATA_DELAY +: 3];
   assign sample_clk_from_synth_o   = st_ff.clk_src[synth_ctl_pkg::BIT_CLK_SOURCE];

   // Soft reset level and calibration handshake
   assign soft_reset_o = st_ff.soft_rst[synth_ctl_pkg::BIT_SOFT_RESET];
   assign cal_start_o  = (st_ff.cal_state == synth_ctl_pkg::CAL_START);
   assign cal_busy_o   = (st_ff.cal_state != synth_ctl_pkg::CAL_IDLE);
   assign reg_rdata_o  = st_ff.rdata;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   property p_trig_start;
      trig_rise && !cal_busy_o |-> ##1 cal_start_o ##1 (cal_busy_o && !cal_start_o);
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger rise did not start calibration");

   property p_srst_cal;
      srst_exit && !cal_busy_o |-> ##1 (cal_start_o && !soft_reset_o);
   endproperty
   a_srst_cal: assert property (p_srst_cal) else $error("soft reset exit did not calibrate");

   property p_busy_not_done;
      cal_busy_o && reg_rd_i && reg_addr_i == synth_ctl_pkg::OFS_STATUS |-> ##1 !reg_rdata_o[0];
   endproperty
   a_busy_not_done: assert property (p_busy_not_done) else $error("status shows done while busy");

   property p_wait_holds;
      (st_ff.cal_state == synth_ctl_pkg::CAL_WAIT) && !done_rise |=> cal_busy_o;
   endproperty
   a_wait_holds: assert property (p_wait_holds) else $error("calibration ended without done");

   property p_drift_read;
      reg_rd_i && reg_addr_i == synth_ctl_pkg::OFS_STATUS
         |-> ##1 reg_rdata_o[2:1] == $past({st_ff.drh_sync[1], st_ff.drl_sync[1]});
   endproperty
   a_drift_read: assert property (p_drift_read) else $error("drift flags misread");

   property p_ref_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_REF_HIGH
         |-> ##1 (ref_divisor_o[9:8] == $past(reg_wdata_i[1:0]))
                 && (output_divisor_o == $past(reg_wdata_i[7:4]));
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("ref/output divider write lost");

   property p_fb_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_FB_LOW
         |-> ##1 feedback_divisor_o[7:0] == $past(reg_wdata_i);
   endproperty
   a_fb_write: assert property (p_fb_write) else $error("feedback divider write lost");

   property p_gate_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_CLK_GATE
         |-> ##1 (sample_clk_gate_o == $past(reg_wdata_i[0]))
                 && (data_clock_delay_cycles_o == $past(reg_wdata_i[3:1]));
   endproperty
   a_gate_write: assert property (p_gate_write) else $error("clock gate or delay write lost");

   property p_enables;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_MASTER_EN
         |-> ##1 {ref_divisor_enable_o, synth_enable_o} == $past(reg_wdata_i[1:0]);
   endproperty
   a_enables: assert property (p_enables) else $error("master enable write lost");

   property p_unmapped;
      reg_rd_i && reg_addr_i == 8'hFF |-> ##1 reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_ref_low_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_REF_LOW
         |-> ##1 ref_divisor_o[7:0] == $past(reg_wdata_i);
   endproperty
   a_ref_low_write: assert property (p_ref_low_write) else $error("reference divider low byte lost");

   property p_fb_high_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_FB_HIGH
         |-> ##1 feedback_divisor_o[11:8] == $past(reg_wdata_i[3:0]);
   endproperty
   a_fb_high_write: assert property (p_fb_high_write) else $error("feedback divider high bits lost");

   property p_pump_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_PUMP
         |-> ##1 pump_current_code_o == $past(reg_wdata_i[3:0]);
   endproperty
   a_pump_write: assert property (p_pump_write) else $error("pump code write lost");

   property p_res_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_FILT_RES
         |-> ##1 filter_resistor_code_o == $past(reg_wdata_i[4:0]);
   endproperty
   a_res_write: assert property (p_res_write) else $error("filter resistor code write lost");

   property p_cap_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_FILT_CAP1
         |-> ##1 filter_cap_one_code_o == $past(reg_wdata_i[4:0]);
   endproperty
   a_cap_write: assert property (p_cap_write) else $error("filter capacitor code write lost");

   property p_bias_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_OUT_BIAS_EN
         |-> ##1 {synth_bias_enable_o, synth_output_enable_o} == $past(reg_wdata_i[1:0]);
   endproperty
   a_bias_write: assert property (p_bias_write) else $error("output or bias enable write lost");

   property p_src_write;
      reg_wr_i && reg_addr_i == synth_ctl_pkg::OFS_CLK_SOURCE
         |-> ##1 sample_clk_from_synth_o == $past(reg_wdata_i[0]);
   endproperty
   a_src_write: assert property (p_src_write) else $error("clock source write lost");

   property p_start_pulse;
      cal_start_o |=> !cal_start_o && cal_busy_o;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse not single or busy lost");

endmodule // synth_ctl

// [core/synth_ctl_pkg.sv]
package synth_ctl_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] OFS_SOFT_RESET  = 8'h00;
   localparam logic [7:0] OFS_CLK_SOURCE  = 8'h53;
   localparam logic [7:0] OFS_REF_LOW     = 8'h54;
   localparam logic [7:0] OFS_REF_HIGH    = 8'h55;
   localparam logic [7:0] OFS_FB_LOW      = 8'h56;
   localparam logic [7:0] OFS_FB_HIGH     = 8'h57;
   localparam logic [7:0] OFS_PUMP        = 8'h58;
   localparam logic [7:0] OFS_MASTER_EN   = 8'h59;
   localparam logic [7:0] OFS_FILT_RES    = 8'h5A;
   localparam logic [7:0] OFS_FILT_CAP3   = 8'h5B;
   localparam logic [7:0] OFS_FILT_CAP1   = 8'h5C;
   localparam logic [7:0] OFS_FILT_CAP2   = 8'h5D;
   localparam logic [7:0] OFS_OUT_BIAS_EN = 8'h5F;
   localparam logic [7:0] OFS_CAL_TRIG    = 8'h6B;
   localparam logic [7:0] OFS_CLK_GATE    = 8'h6D;
   localparam logic [7:0] OFS_STATUS      = 8'hD1;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_SOFT_RESET   = 0;
   localparam int BIT_CLK_SOURCE   = 0;
   localparam int BIT_SYNTH_EN     = 0;
   localparam int BIT_REFDIV_EN    = 1;
   localparam int BIT_OUT_EN       = 0;
   localparam int BIT_BIAS_EN      = 1;
   localparam int BIT_CAL_TRIG     = 0;
   localparam int BIT_CLK_GATE     = 0;
   localparam int LSB_DATA_DELAY   = 1;
   localparam int LSB_OUT_DIV      = 4;
   localparam int BIT_STAT_CAL_OK  = 0;
   localparam int BIT_STAT_DRIFT_L = 1;
   localparam int BIT_STAT_DRIFT_H = 2;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_REG     = 8'h00;
   localparam logic [7:0] RST_REF_LOW = 8'h01;
   localparam logic [7:0] RST_FB_LOW  = 8'h01;
   localparam logic [7:0] RST_PUMP    = 8'h04;

   // ************************************************************
   // Calibration sequencer states
   // ************************************************************
   typedef enum logic [1:0] {
      CAL_IDLE  = 2'b00,
      CAL_START = 2'b01,
      CAL_WAIT  = 2'b10
   } cal_state_e;

endpackage

// [verification/synth_ctl_tb_top.sv]
`timescale 1ns/10ps

module synth_ctl_tb_top;

   // ************************************************************
   // Stimulus and observed signals
   // ************************************************************
   logic        core_clk_i   = 1'b0;
   logic        rstn_i       = 1'b0;
   logic [7:0]  reg_addr_i   = 8'h00;
   logic [7:0]  reg_wdata_i  = 8'h00;
   logic        reg_wr_i     = 1'b0;
   logic        reg_rd_i     = 1'b0;
   logic        cal_done_i   = 1'b0;
   logic        drift_low_i  = 1'b0;
   logic        drift_high_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic [9:0]  ref_divisor_o;
   logic [11:0] feedback_divisor_o;
   logic [3:0]  output_divisor_o, pump_current_code_o;
   logic [4:0]  filter_resistor_code_o, filter_cap_one_code_o, filter_cap_two_code_o, filter_cap_three_code_o;
   logic        synth_enable_o, ref_divisor_enable_o, synth_output_enable_o, synth_bias_enable_o;
   logic        sample_clk_gate_o, sample_clk_from_synth_o, soft_reset_o, cal_start_o, cal_busy_o;
   logic [2:0]  data_clock_delay_cycles_o;
   logic [59:0] obs;
   logic [7:0]  sh [256];
   logic [7:0]  rdv;
   logic [23:0] rows [25];
   int          num_errors = 0;
   int          checks     = 0;
   int          starts     = 0;
   int          cyc        = 0;
   int          n;

   synth_ctl dut (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cal_done_i(cal_done_i),
      .drift_low_i(drift_low_i), .drift_high_i(drift_high_i), .ref_divisor_o(ref_divisor_o),
      .feedback_divisor_o(feedback_divisor_o), .output_divisor_o(output_divisor_o),
      .pump_current_code_o(pump_current_code_o), .filter_resistor_code_o(filter_resistor_code_o),
      .filter_cap_one_code_o(filter_cap_one_code_o), .filter_cap_two_code_o(filter_cap_two_code_o),
      .filter_cap_three_code_o(filter_cap_three_code_o), .synth_enable_o(synth_enable_o),
      .ref_divisor_enable_o(ref_divisor_enable_o), .synth_output_enable_o(synth_output_enable_o),
      .synth_bias_enable_o(synth_bias_enable_o), .sample_clk_gate_o(sample_clk_gate_o),
      .data_clock_delay_cycles_o(data_clock_delay_cycles_o), .sample_clk_from_synth_o(sample_clk_from_synth_o),
      .soft_reset_o(soft_reset_o), .cal_start_o(cal_start_o), .cal_busy_o(cal_busy_o));

   // All configuration outputs side by side, same order as exp_vec
   assign obs = {ref_divisor_o, feedback_divisor_o, output_divisor_o, pump_current_code_o,
                 filter_resistor_code_o, filter_cap_one_code_o, filter_cap_two_code_o, filter_cap_three_code_o,
                 synth_enable_o, ref_divisor_enable_o, synth_output_enable_o, synth_bias_enable_o,
                 sample_clk_gate_o, data_clock_delay_cycles_o, sample_clk_from_synth_o, soft_reset_o};

   // ************************************************************
   // Clock, pulse counter, hang guard
   // ************************************************************
   initial begin
      forever #2 core_clk_i = ~core_clk_i;
   end

   // Counted so that a dropped request shows as a missing pulse
   always @(posedge core_clk_i) begin
      if (cal_start_o === 1'b1) starts++;
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         conclude();
      end
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic conclude();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // One-cycle strobe; returns just after the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask

   task automatic shadow_reset();
      foreach (sh[i]) sh[i] = synth_ctl_pkg::RST_REG;
      sh[8'h54] = synth_ctl_pkg::RST_REF_LOW;
      sh[8'h56] = synth_ctl_pkg::RST_FB_LOW;
      sh[8'h58] = synth_ctl_pkg::RST_PUMP;
   endtask

   function automatic logic [59:0] exp_vec();
      return {sh[8'h55][1:0], sh[8'h54], sh[8'h57][3:0], sh[8'h56], sh[8'h55][7:4], sh[8'h58][3:0],
              sh[8'h5A][4:0], sh[8'h5C][4:0], sh[8'h5D][4:0], sh[8'h5B][4:0], sh[8'h59][0], sh[8'h59][1],
              sh[8'h5F][0], sh[8'h5F][1], sh[8'h6D][0], sh[8'h6D][3:1], sh[8'h53][0], sh[8'h00][0]};
   endfunction

   task automatic wait_idle();
      n = 0;
      while (cal_busy_o !== 1'b0 && n < 12) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      chk("busy drops after done", 1, n <= 6);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      // Address, write data, read-back expected; 0x60 is unmapped
      // Tail rows: 100 MHz reference to 1.2 GHz, divide by 6, mid-band filter
      rows = '{24'h54FFFF, 24'h55F3F3, 24'h56FFFF, 24'h570F0F, 24'h580F0F, 24'h5A1F1F, 24'h5B0707,
               24'h5C0808, 24'h5D0101, 24'h590303, 24'h5F0202, 24'h6D0F0F, 24'h530101, 24'h60AA00,
               24'h540A0A, 24'h556060, 24'h567878, 24'h570000, 24'h6D0E0E, 24'h5F0101,
               24'h580404, 24'h5A1F1F, 24'h5B0202, 24'h5D0101, 24'h5C0101};
      shadow_reset();
      repeat (12) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      #1;
      chk("reset outputs", exp_vec(), obs);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         sh[rows[i][23:16]] = rows[i][15:8];
         chk("config outputs", exp_vec(), obs);
         rd(rows[i][23:16], rdv);
         chk("read back", rows[i][7:0], rdv);
      end
      // Recalibrate after the divider rewrite; trigger rise starts one
      wr(8'h6B, 8'h01);
      chk("start pulse", 2'b11, {cal_start_o, cal_busy_o});
      rd(8'hD1, rdv);
      chk("done low while busy", 8'h00, rdv);
      wr(8'h6B, 8'h00);
      wr(8'h6B, 8'h01);
      chk("request dropped while busy", 1, starts);
      @(posedge core_clk_i);
      cal_done_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk("busy holds through sync", 1, cal_busy_o);
      wait_idle();
      wr(8'hD1, 8'hFF);
      rd(8'hD1, rdv);
      chk("status done, write ignored", 8'h01, rdv);
      // Leaving soft reset calibrates again
      @(posedge core_clk_i);
      cal_done_i <= 1'b0;
      wr(8'h6B, 8'h00);
      wr(8'h00, 8'h01);
      chk("soft reset held, no start", 4'b1001, {soft_reset_o, cal_start_o, starts[1:0]});
      wr(8'h00, 8'h00);
      chk("start on soft reset exit", 2'b11, {cal_start_o, cal_busy_o});
      rd(8'hD1, rdv);
      chk("done low again", 8'h00, rdv);
      @(posedge core_clk_i);
      cal_done_i <= 1'b1;
      wait_idle();
      chk("two starts seen", 2, starts);
      // Drift flags through their synchronisers
      @(posedge core_clk_i);
      drift_low_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rd(8'hD1, rdv);
      chk("drift low flag", 8'h03, rdv);
      @(posedge core_clk_i);
      drift_low_i <= 1'b0;
      drift_high_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rd(8'hD1, rdv);
      chk("drift high flag", 8'h05, rdv);
      // Reset in mid-run restores every default
      @(posedge core_clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      #1;
      shadow_reset();
      chk("outputs after second reset", exp_vec(), obs);
      rd(8'h55, rdv);
      chk("register after second reset", 8'h00, rdv);
      conclude();
   end

endmodule // synth_ctl_tb_top
